// *** wwd_params.svh ***
// Purpose: constants for the windowed watchdog
// Assumes: 32-bit Avalon-MM word registers, byte addresses
// Notes: included by the watchdog module only; the package does not include it
`ifndef WWD_PARAMS_SVH
`define WWD_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define WWD_OFF_CTRL_FIRST 4'h0
`define WWD_OFF_CTRL_SECOND 4'h4
`define WWD_OFF_COUNT 4'h8
`define WWD_OFF_CAUSE 4'hc

// ----------------------------------------
// field positions
// ----------------------------------------
`define WWD_SEN_BIT 0
`define WWD_PS_LSB 1
`define WWD_PS_MSB 5
`define WWD_WIN_LSB 0
`define WWD_WIN_MSB 2
`define WWD_CS_LSB 4
`define WWD_CS_MSB 6
`define WWD_CNT_PRE_LSB 0
`define WWD_CNT_PRE_MSB 17
`define WWD_CNT_TMR_LSB 18
`define WWD_CNT_TMR_MSB 22
`define WWD_WD_RESET_FLAG_BIT 0
`define WWD_TO_BIT 1
`define WWD_PD_BIT 2
`define WWD_WV_BIT 3

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define WWD_PS_RUNTIME 5'h1f
`define WWD_PS_RESET 5'h0b
`define WWD_PS_MAX 5'h12
`define WWD_PS_MIN 5'h00
`define WWD_WIN_RUNTIME 3'h7
`define WWD_CS_RUNTIME 3'h7
`define WWD_CS_RESET 3'h0
`define WWD_CS_LFO 3'h0
`define WWD_CS_MFO 3'h1
`define WWD_CS_SOSC 3'h2
`define WWD_PRE_ONE 18'h00001
`define WWD_TMR_ONE 5'h01
`define WWD_TMR_FULL 5'h1f

`endif

// *** wwd_pkg.sv ***
// Purpose: types shared by the windowed watchdog
// Assumes: nothing beyond the params header
// Notes: mode encoding follows the configuration field
package wwd_pkg;

   // ----------------------------------------
   // operating mode of the configuration field
   // ----------------------------------------
   typedef enum logic [1:0] {
      WWD_MODE_OFF = 2'h0,
      WWD_MODE_SOFT = 2'h1,
      WWD_MODE_AWAKE = 2'h2,
      WWD_MODE_ON = 2'h3
   } wwd_mode_type;

   // ----------------------------------------
   // bus handshake state, gray from idle to answer to done; both bits flip on the return to idle
   // ----------------------------------------
   typedef enum logic [1:0] {
      WWD_BUS_IDLE = 2'b00,
      WWD_BUS_ANSWER = 2'b01,
      WWD_BUS_DONE = 2'b11
   } wwd_bus_type;

endpackage : wwd_pkg

// *** wwd_watchdog.sv ***
// Purpose: windowed watchdog timer with Avalon-MM register slave
// Assumes: oscillator ticks are one-cycle enables on core_clk
// Notes: every slow rate enters as a tick; one clock domain only
`timescale 1ns/100ps
`include "wwd_params.svh"

module wwd_watchdog #(
   parameter int PRE_W = 18,
   parameter int TMR_W = 5
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // configuration word fields
   input wire wwd_pkg::wwd_mode_type wdModeCfg,
   input wire logic [2:0] cfgClockPick,
   input wire logic [4:0] cfgPeriodPick,
   input wire logic [2:0] cfgWindowPick,
   // oscillator ticks
   input wire logic lowFreqOscTick,
   input wire logic midFreqOscTick,
   input wire logic secondaryOscTick,
   // core events
   input wire logic watchdogClearInstr,
   input wire logic sleepEnter,
   input wire logic inSleep,
   input wire logic inIdle,
   input wire logic wakeByInterrupt,
   input wire logic oscStartupTimer,
   input wire logic oscFailDetected,
   // outputs to core
   output logic wdResetReq,
   output logic wdWakeReq,
   output logic armed
);
   import wwd_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // open when the five count msbs reach the window delay
   // window 000 opens at count 28 of 32, window 110 at count 4
   function automatic logic windowOpen(input logic [2:0] win,
                                       input logic [4:0] tmr);
      windowOpen = tmr >= {~win, 2'b00};
   endfunction : windowOpen

   // config value wins unless it holds its runtime code
   function automatic logic [2:0] pick3(input logic [2:0] cfg,
                                        input logic [2:0] rt);
      pick3 = (cfg == 3'h7) ? rt : cfg;
   endfunction : pick3

   // ----------------------------------------
   // state
   // ----------------------------------------
   wwd_bus_type busState, next_busState;
   logic [31:0] readData, next_readData;
   logic [4:0] intervalPick, next_intervalPick;
   logic softEnable, next_softEnable;
   logic [2:0] clockPick, next_clockPick;
   logic [2:0] windowPick, next_windowPick;
   logic [PRE_W-1:0] prescale, next_prescale;
   logic [TMR_W-1:0] wdCount, next_wdCount;
   logic next_armed;
   logic wdResetFlag, next_wdResetFlag;
   logic expiryFlagN, next_expiryFlagN;
   logic sleepEnteredFlagN, next_sleepEnteredFlagN;
   logic windowViolationFlagN, next_windowViolationFlagN;
   logic next_wdResetReq, next_wdWakeReq;
   logic initDone, next_initDone;

   // decoded values
   logic accept, isRead, isWrite;
   logic hitFirst, hitSecond, hitCount, hitCause;
   logic active, tick, windowed, isOpen;
   logic [4:0] periodCode, effCode;
   logic [2:0] effClock, effWindow;
   logic [PRE_W-1:0] preLimit;
   logic holdClear, timeout, clearReq;
   logic [31:0] regValue;

   // ----------------------------------------
   // combinational decode
   // ----------------------------------------
   // address decode for the four words
   always_comb begin
      hitFirst = 1'b0;
      hitSecond = 1'b0;
      hitCount = 1'b0;
      hitCause = 1'b0;
      if (avs_address == `WWD_OFF_CTRL_FIRST) begin
         hitFirst = 1'b1;
      end else if (avs_address == `WWD_OFF_CTRL_SECOND) begin
         hitSecond = 1'b1;
      end else if (avs_address == `WWD_OFF_COUNT) begin
         hitCount = 1'b1;
      end else if (avs_address == `WWD_OFF_CAUSE) begin
         hitCause = 1'b1;
      end
   end

   // read mux; unmapped words read zero
   always_comb begin
      regValue = 32'h0;
      if (hitFirst) begin
         regValue[`WWD_PS_MSB:`WWD_PS_LSB] = intervalPick;
         regValue[`WWD_SEN_BIT] = softEnable;
      end else if (hitSecond) begin
         regValue[`WWD_CS_MSB:`WWD_CS_LSB] = clockPick;
         regValue[`WWD_WIN_MSB:`WWD_WIN_LSB] = windowPick;
      end else if (hitCount) begin
         regValue[`WWD_CNT_PRE_MSB:`WWD_CNT_PRE_LSB] = prescale;
         regValue[`WWD_CNT_TMR_MSB:`WWD_CNT_TMR_LSB] = wdCount;
      end else if (hitCause) begin
         regValue[`WWD_WD_RESET_FLAG_BIT] = wdResetFlag;
         regValue[`WWD_TO_BIT] = expiryFlagN;
         regValue[`WWD_PD_BIT] = sleepEnteredFlagN;
         regValue[`WWD_WV_BIT] = windowViolationFlagN;
      end
   end

   // watchdog decode
   always_comb begin
      accept = (busState == WWD_BUS_ANSWER);
      isRead = accept && avs_read;
      isWrite = accept && avs_write;
      avs_waitrequest = (avs_read || avs_write) && !accept;
      // operating mode
      case (wdModeCfg)
         WWD_MODE_ON: active = 1'b1;
         WWD_MODE_AWAKE: active = !inSleep;
         WWD_MODE_SOFT: active = softEnable;
         default: active = 1'b0;
      endcase
      // clock source; off and soft modes use the runtime select, awake and on the config field unless it holds the runtime code
      effClock = wdModeCfg[1] ? pick3(cfgClockPick, clockPick)
                              : clockPick;
      case (effClock)
         `WWD_CS_LFO: tick = lowFreqOscTick;
         `WWD_CS_MFO: tick = midFreqOscTick;
         `WWD_CS_SOSC: tick = secondaryOscTick;
         default: tick = 1'b0; // reserved sources never tick
      endcase
      // interval: reserved codes fall back to the minimum
      periodCode = (cfgPeriodPick == `WWD_PS_RUNTIME) ? intervalPick
                                                      : cfgPeriodPick;
      effCode = (periodCode > `WWD_PS_MAX) ? `WWD_PS_MIN : periodCode;
      preLimit = (`WWD_PRE_ONE << effCode) - `WWD_PRE_ONE;
      // window
      effWindow = pick3(cfgWindowPick, windowPick);
      windowed = (effWindow != `WWD_WIN_RUNTIME);
      isOpen = windowOpen(effWindow, wdCount);
      timeout = active && tick && (prescale == preLimit)
                && (wdCount == `WWD_TMR_FULL);
      clearReq = watchdogClearInstr && active;
      // a control write restarts the count so that a new interval or
      // source never runs on from a stale prescaler value
      // the core divider is not an input; count is unaffected
      holdClear = !active || sleepEnter || wakeByInterrupt
                  || oscStartupTimer || oscFailDetected
                  || (isWrite && (hitFirst || hitSecond));
   end

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   // bus handshake answers one cycle after the request appears
   // the done state keeps back-to-back requests one cycle apart
   always_comb begin
      next_busState = busState;
      next_readData = readData;
      case (busState)
         WWD_BUS_IDLE: begin
            if (avs_read || avs_write) begin
               next_busState = WWD_BUS_ANSWER;
               next_readData = regValue;
            end
         end
         WWD_BUS_ANSWER: next_busState = WWD_BUS_DONE;
         default: next_busState = WWD_BUS_IDLE;
      endcase
   end

   // registers, counter, flags
   // later assignments win: reset-time loads, software writes, then
   // hardware events, so a status event beats a same-cycle flag write
   // and every clear condition beats counting
   always_comb begin
      next_intervalPick = intervalPick;
      next_softEnable = softEnable;
      next_clockPick = clockPick;
      next_windowPick = windowPick;
      next_prescale = prescale;
      next_wdCount = wdCount;
      next_armed = armed;
      next_wdResetFlag = wdResetFlag;
      next_expiryFlagN = expiryFlagN;
      next_sleepEnteredFlagN = sleepEnteredFlagN;
      next_windowViolationFlagN = windowViolationFlagN;
      next_wdResetReq = 1'b0;
      next_wdWakeReq = 1'b0;
      next_initDone = 1'b1;
      // reset values caught one cycle after release
      if (!initDone) begin
         next_intervalPick = (cfgPeriodPick == `WWD_PS_RUNTIME)
                             ? `WWD_PS_RESET : cfgPeriodPick;
         next_clockPick = (cfgClockPick == `WWD_CS_RUNTIME)
                          ? `WWD_CS_RESET : cfgClockPick;
         next_windowPick = cfgWindowPick;
      end
      // software writes; read-only fields ignore the write
      if (isWrite && hitFirst) begin
         if (cfgPeriodPick == `WWD_PS_RUNTIME) begin
            next_intervalPick = avs_writedata[`WWD_PS_MSB:`WWD_PS_LSB];
         end
         next_softEnable = avs_writedata[`WWD_SEN_BIT];
      end
      if (isWrite && hitSecond) begin
         if (cfgClockPick == `WWD_CS_RUNTIME) begin
            next_clockPick = avs_writedata[`WWD_CS_MSB:`WWD_CS_LSB];
         end
         if (cfgWindowPick == `WWD_WIN_RUNTIME) begin
            next_windowPick = avs_writedata[`WWD_WIN_MSB:`WWD_WIN_LSB];
         end
      end
      if (isWrite && hitCause) begin
         next_wdResetFlag = avs_writedata[`WWD_WD_RESET_FLAG_BIT];
         next_expiryFlagN = avs_writedata[`WWD_TO_BIT];
         next_sleepEnteredFlagN = avs_writedata[`WWD_PD_BIT];
         next_windowViolationFlagN = avs_writedata[`WWD_WV_BIT];
      end
      // reading the first control word arms the clear
      if (isRead && hitFirst) begin
         next_armed = 1'b1;
      end
      // counting; prescaler tap sets the interval
      if (active && tick) begin
         if (prescale == preLimit) begin
            next_prescale = '0;
            next_wdCount = wdCount + `WWD_TMR_ONE;
         end else begin
            next_prescale = prescale + `WWD_PRE_ONE;
         end
      end
      if (sleepEnter) begin
         next_sleepEnteredFlagN = 1'b0;
      end
      // clear instruction: windowed mode checks arming and window
      if (clearReq) begin
         next_armed = 1'b0;
         if (windowed && (!armed || !isOpen)) begin
            next_wdResetReq = 1'b1;
            next_windowViolationFlagN = 1'b0;
         end else begin
            next_prescale = '0;
            next_wdCount = '0;
            next_expiryFlagN = 1'b1;
            next_sleepEnteredFlagN = 1'b1;
         end
      end
      // time-out: wake from sleep or idle, else reset
      if (timeout) begin
         if (inSleep) begin
            next_wdWakeReq = 1'b1;
            next_expiryFlagN = 1'b0;
            next_sleepEnteredFlagN = 1'b0;
         end else if (inIdle) begin
            next_wdWakeReq = 1'b1;
         end else begin
            next_wdResetReq = 1'b1;
            next_expiryFlagN = 1'b0;
         end
         next_wdResetFlag = 1'b1;
      end
      // clear conditions outrank counting
      if (holdClear) begin
         next_prescale = '0;
         next_wdCount = '0;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // bus handshake group; readback word stands until the next request
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         busState <= WWD_BUS_IDLE;
         readData <= 32'h0;
      end else begin
         busState <= next_busState;
         readData <= next_readData;
      end
   end

   // software selects; config fields are caught one edge after release
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         intervalPick <= `WWD_PS_RESET;
         softEnable <= 1'b0;
         clockPick <= `WWD_CS_RESET;
         windowPick <= `WWD_WIN_RUNTIME;
         initDone <= 1'b0;
      end else begin
         intervalPick <= next_intervalPick;
         softEnable <= next_softEnable;
         clockPick <= next_clockPick;
         windowPick <= next_windowPick;
         initDone <= next_initDone;
      end
   end

   // counter, arming, status flags and request pulses
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prescale <= '0;
         wdCount <= '0;
         armed <= 1'b0;
         wdResetFlag <= 1'b0;
         expiryFlagN <= 1'b1;
         sleepEnteredFlagN <= 1'b1;
         windowViolationFlagN <= 1'b1;
         wdResetReq <= 1'b0;
         wdWakeReq <= 1'b0;
      end else begin
         prescale <= next_prescale;
         wdCount <= next_wdCount;
         armed <= next_armed;
         wdResetFlag <= next_wdResetFlag;
         expiryFlagN <= next_expiryFlagN;
         sleepEnteredFlagN <= next_sleepEnteredFlagN;
         windowViolationFlagN <= next_windowViolationFlagN;
         wdResetReq <= next_wdResetReq;
         wdWakeReq <= next_wdWakeReq;
      end
   end

   // data output straight from its flip-flops
   assign avs_readdata = readData;

endmodule : wwd_watchdog

// *** wwd_watchdog_properties.sv ***
// Purpose: port assertions for the windowed watchdog
// Assumes: one clock, synchronous reset, ticks from the bench
// Notes: bound to wwd_watchdog below the module
`timescale 1ns/100ps
module wwd_watchdog_check (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire wwd_pkg::wwd_mode_type wdModeCfg,
   input wire logic [2:0] cfgWindowPick,
   input wire logic watchdogClearInstr,
   input wire logic inSleep,
   input wire logic inIdle,
   input wire logic oscStartupTimer,
   input wire logic wdResetReq,
   input wire logic wdWakeReq,
   input wire logic armed
);
   import wwd_pkg::*;
   // ----------------------------------------
   // bus and watchdog relations
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_wait_one: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read not answered after one cycle");
   a_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest high with no request");
   a_arm_read: assert property (
      avs_read && !avs_waitrequest && avs_address == 4'h0 |=> armed)
      else $error("arming read did not arm");
   a_clear_disarm: assert property (
      watchdogClearInstr && wdModeCfg == WWD_MODE_ON |=> !armed)
      else $error("clear left watchdog armed");
   // an unarmed clear while windowed must reset even with the window open
   a_unarmed_clear: assert property (
      watchdogClearInstr && !armed && cfgWindowPick != 3'h7 && wdModeCfg == WWD_MODE_ON
      && !inSleep && !inIdle && !oscStartupTimer |=> wdResetReq)
      else $error("unarmed windowed clear gave no reset");
   a_reset_pulse: assert property (wdResetReq |=> !wdResetReq)
      else $error("reset request longer than one cycle");
   a_wake_pulse: assert property (wdWakeReq |=> !wdWakeReq)
      else $error("wake request longer than one cycle");
   a_off_quiet: assert property (
      wdModeCfg == WWD_MODE_OFF && $past(wdModeCfg) == WWD_MODE_OFF
      |-> !wdResetReq && !wdWakeReq)
      else $error("request while watchdog off");
   a_sleep_noreset: assert property (inSleep && $past(inSleep) |-> !wdResetReq)
      else $error("reset request during sleep");
   c_reset: cover property (wdResetReq);
   c_wake: cover property (wdWakeReq);
   c_arm: cover property (avs_read && !avs_waitrequest && avs_address == 4'h0);
endmodule : wwd_watchdog_check

bind wwd_watchdog wwd_watchdog_check u_wwd_watchdog_check (
   .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .wdModeCfg(wdModeCfg), .cfgWindowPick(cfgWindowPick),
   .watchdogClearInstr(watchdogClearInstr), .inSleep(inSleep), .inIdle(inIdle),
   .oscStartupTimer(oscStartupTimer), .wdResetReq(wdResetReq),
   .wdWakeReq(wdWakeReq), .armed(armed));

// *** wwd_core_model.sv ***
// Purpose: core side model, bus master and clear instructions
// Assumes: avalon-mm slave answers with waitrequest
// Notes: released lines show inverted data, never the last value
`timescale 1ns/100ps
module wwd_core_model (
   input wire logic core_clk,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   output logic [3:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic watchdogClearInstr
);
   // ----------------------------------------
   // bus and instruction tasks
   // ----------------------------------------
   initial begin
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      watchdogClearInstr = 1'b0;
   end
   // write, also used to set the soft enable
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_address <= ~a;
      avs_writedata <= ~d;
   endtask : bus_wr
   // read of the first control word arms the watchdog
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      avs_address <= ~a;
   endtask : bus_rd
   task automatic clr();
      @(posedge core_clk);
      watchdogClearInstr <= 1'b1;
      @(posedge core_clk);
      watchdogClearInstr <= 1'b0;
   endtask : clr
endmodule : wwd_core_model

// *** test_windowed_watchdog_timer.sv ***
// Purpose: self-checking bench for the windowed watchdog
// Assumes: low-frequency tick every cycle, so periods are short
// Notes: period checks allow a few cycles of pipeline slack
`timescale 1ns/100ps
module test_windowed_watchdog_timer;
   import wwd_pkg::*;
   logic core_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   wwd_mode_type wdModeCfg;
   logic [4:0] cfgPeriodPick;
   logic [2:0] cfgWindowPick;
   logic lowFreqOscTick, midFreqOscTick, watchdogClearInstr, sleepEnter, inSleep, inIdle;
   logic wakeByInterrupt, oscStartupTimer, wdResetReq, wdWakeReq, armed;
   logic [7:0] c;
   int errTotal = 0, checkCount = 0, cycles = 0, r, w, n;
   // mode, sen, sleep, idle, startup, expect reset, expect wake
   // packed tables, listed last entry first so that index 0 is the first case
   localparam logic [8:0][7:0] CASES = {8'hc4, 8'h20, 8'h40, 8'h71, 8'hc9, 8'hd1,
      8'h90, 8'h82, 8'hc2};
   localparam logic [3:0][4:0] PCFG = {5'h01, 5'h1f, 5'h1f, 5'h1f};
   localparam logic [3:0][4:0] PCODE = {5'h00, 5'h13, 5'h01, 5'h00};
   localparam logic [3:0][7:0] PEXP = {8'h40, 8'h20, 8'h40, 8'h20};

   wwd_watchdog u_wwd_watchdog (.core_clk(core_clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .wdModeCfg(wdModeCfg), .cfgClockPick(3'h7),
      .cfgPeriodPick(cfgPeriodPick), .cfgWindowPick(cfgWindowPick),
      .lowFreqOscTick(lowFreqOscTick), .midFreqOscTick(midFreqOscTick),
      .secondaryOscTick(1'b0),
      .watchdogClearInstr(watchdogClearInstr), .sleepEnter(sleepEnter),
      .inSleep(inSleep), .inIdle(inIdle), .wakeByInterrupt(wakeByInterrupt),
      .oscStartupTimer(oscStartupTimer), .oscFailDetected(1'b0),
      .wdResetReq(wdResetReq), .wdWakeReq(wdWakeReq), .armed(armed));
   wwd_core_model u_wwd_core_model (.core_clk(core_clk),
      .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .watchdogClearInstr(watchdogClearInstr));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // a hang anywhere ends in the same verdict
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errTotal++;
         $display("ERROR timeout expected 0 seen 1");
         endSim();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checkCount++;
      if (g !== e) begin
         errTotal++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic watch(input int cyc);
      r = 0;
      w = 0;
      repeat (cyc) begin
         @(posedge core_clk);
         if (wdResetReq === 1'b1) r++;
         if (wdWakeReq === 1'b1) w++;
      end
   endtask : watch
   task automatic endSim();
      $display("checks %0d errors %0d", checkCount, errTotal);
      if (errTotal == 0 && checkCount > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : endSim

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      sys_rst = 1'b1;
      wdModeCfg = WWD_MODE_ON;
      cfgPeriodPick = 5'h1f;
      cfgWindowPick = 3'h7;
      lowFreqOscTick = 1'b1;
      midFreqOscTick = 1'b0;
      {sleepEnter, inSleep, inIdle, wakeByInterrupt, oscStartupTimer} = 5'h00;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      u_wwd_core_model.bus_rd(4'h0, rd);
      chk("interval reset", 32'h16, rd & 32'h3f);
      u_wwd_core_model.bus_rd(4'h4, rd);
      chk("clock reset", 32'h0, rd & 32'h70);
      u_wwd_core_model.bus_rd(4'hc, rd);
      chk("flags reset", 32'he, rd & 32'hf);
      u_wwd_core_model.bus_rd(4'h3, rd);
      chk("unmapped", 32'h0, rd);
      // write clears the count, so the period runs from its end
      for (int i = 0; i < 4; i++) begin
         cfgPeriodPick <= PCFG[i];
         u_wwd_core_model.bus_wr(4'h0, {26'h0, PCODE[i], 1'b0});
         n = 0;
         do begin
            @(posedge core_clk);
            n++;
         end while (wdResetReq !== 1'b1 && n < 300);
         chk("period", 32'h1, 32'(n >= PEXP[i] - 2 && n <= PEXP[i] + 3));
      end
      cfgPeriodPick <= 5'h1f;
      u_wwd_core_model.bus_rd(4'hc, rd);
      chk("timeout flags", 32'h1, rd & 32'h3);
      for (int i = 0; i < 9; i++) begin
         c = CASES[i];
         wdModeCfg <= wwd_mode_type'(c[7:6]);
         inSleep <= c[4];
         inIdle <= c[3];
         oscStartupTimer <= c[2];
         u_wwd_core_model.bus_wr(4'h0, {31'h0, c[5]});
         sleepEnter <= c[4];
         @(posedge core_clk);
         sleepEnter <= 1'b0;
         watch(80);
         chk("reset seen", 32'(c[1]), 32'(r > 0));
         chk("wake seen", 32'(c[0]), 32'(w > 0));
         {inSleep, inIdle, oscStartupTimer} <= 3'h0;
         wakeByInterrupt <= c[4];
         @(posedge core_clk);
         wakeByInterrupt <= 1'b0;
      end
      wdModeCfg <= WWD_MODE_ON;
      u_wwd_core_model.bus_wr(4'h0, 32'h6);
      u_wwd_core_model.clr();
      watch(4);
      chk("plain clear", 32'h0, 32'(r));
      cfgWindowPick <= 3'h0;
      u_wwd_core_model.bus_wr(4'h0, 32'h6);
      u_wwd_core_model.clr();
      watch(4);
      chk("unarmed clear", 32'h1, 32'(r));
      u_wwd_core_model.bus_rd(4'hc, rd);
      chk("violation flag", 32'h0, 32'(rd[3]));
      u_wwd_core_model.bus_wr(4'hc, 32'hf);
      u_wwd_core_model.bus_rd(4'hc, rd);
      chk("flag set back", 32'h1, 32'(rd[3]));
      u_wwd_core_model.bus_wr(4'h0, 32'h6);
      u_wwd_core_model.bus_rd(4'h0, rd);
      #1 chk("armed", 32'h1, 32'(armed));
      u_wwd_core_model.clr();
      watch(4);
      chk("closed clear", 32'h1, 32'(r));
      // eighth window opens at count 28, tick 224 of 256
      u_wwd_core_model.bus_wr(4'h0, 32'h6);
      repeat (232) @(posedge core_clk);
      u_wwd_core_model.bus_rd(4'h0, rd);
      u_wwd_core_model.clr();
      watch(6);
      chk("open clear", 32'h0, 32'(r));
      chk("disarmed", 32'h0, 32'(armed));
      // runtime window and clock select through the second control word
      cfgWindowPick <= 3'h7;
      u_wwd_core_model.bus_wr(4'h4, 32'h10);
      u_wwd_core_model.bus_rd(4'h4, rd);
      chk("second word", 32'h10, rd & 32'h77);
      u_wwd_core_model.clr();
      watch(4);
      chk("runtime window", 32'h1, 32'(r));
      // mid source picked but silent: count must stall at zero
      u_wwd_core_model.bus_wr(4'h0, 32'h0);
      watch(80);
      chk("stalled reset", 32'h0, 32'(r));
      u_wwd_core_model.bus_rd(4'h8, rd);
      chk("stalled count", 32'h0, rd);
      midFreqOscTick <= 1'b1;
      watch(80);
      chk("mid source", 32'h1, 32'(r > 0));
      endSim();
   end
endmodule : test_windowed_watchdog_timer
